// ### rmx_pkg.sv
// Function
// - Floating-point instruction with emulate or task-switched bit set raises vector 7.
// - Task-switched bit set also makes a wait instruction raise vector 7.
// - Numeric operand crossing its segment limit raises 13; FPU pointers stay unchanged.
// - Unmasked FPU error is recorded; next FPU or wait instruction raises 16.
// - No-wait init, clear, store status, store env, save never raise 16.
// - Reset or power-up starts the device in real mode.
// - Real mode defaults to 16-bit operands; 32 bits only by override prefix.
// - Bus-lock prefix on a form not permitted raises exception 6.
// - Lock allowed only on listed memory-destination forms, never on repeated strings.
// - Lock legality ignores I/O privilege level and current privilege level.
// - Real-mode physical address is segment shifted four plus offset, no paging.
// - Real mode limits memory to one megabyte; only A19-A2 active.
// - After reset, code cycles drive A31-A2 high until first far jump or call.
// - Data or fetch past offset FFFFH in real mode raises exception 13.
// - Real-mode stack reference past FFFFH raises 12, return before instruction.
// - Real-mode interrupt vector beyond table limit raises 8, return before instruction.
// - Exceptions 10, 11, 14 and 17 never occur in real mode.
// - Bytes 00000H-003FFH hold 256 four-byte interrupt vectors.
// - Halt stops execution and bus until NMI, enabled maskable request, or reset.
// - Shutdown on 8 or 13 beyond table limit, or odd stack pointer wrap.
// - NMI leaves shutdown only if limit at least 0017H and stack pointer over 0005H.
package rmx_pkg;
  localparam logic [1:0] OFS_CTRL = 2'h0;
  localparam logic [1:0] OFS_IDT_LIMIT = 2'h1;
  localparam logic [1:0] OFS_STATUS = 2'h2;
  localparam int CTRL_EM_BIT = 0;
  localparam int CTRL_TS_BIT = 1;
  localparam int CTRL_MP_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h0;
  localparam logic [15:0] IDT_LIMIT_RESET = 16'h03ff;
  localparam logic [7:0] VEC_INVALID_OP = 8'h06;
  localparam logic [7:0] VEC_NO_DEVICE = 8'h07;
  localparam logic [7:0] VEC_DOUBLE = 8'h08;
  localparam logic [7:0] VEC_STACK = 8'h0c;
  localparam logic [7:0] VEC_GENERAL = 8'h0d;
  localparam logic [7:0] VEC_FPU_ERR = 8'h10;
  localparam logic [31:0] SEG_LAST_OFS = 32'h0000_ffff;
  localparam logic [15:0] NMI_LIMIT_MIN = 16'h0017;
  localparam logic [15:0] NMI_SP_MIN = 16'h0005;
  localparam logic [20:0] VECTOR_AREA_END = 21'h00_03ff;

  typedef enum logic [2:0] {
    LK_NONE    = 3'b000,
    LK_BIT     = 3'b001,
    LK_EXCHANGE_OP    = 3'b010,
    LK_ALU     = 3'b011,
    LK_UNARY   = 3'b100,
    LK_CMPXADD = 3'b101
  } lock_class_t;

  typedef enum logic [1:0] {
    MK_CODE  = 2'b00,
    MK_DATA  = 2'b01,
    MK_STACK = 2'b10
  } mem_kind_t;

  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_HALT = 2'b01,
    ST_SHUT = 2'b10
  } run_state_t;

  typedef struct packed {
    logic        valid;
    logic        fpu;
    logic        wait_op;
    logic        nowait;
    logic        lock;
    lock_class_t lock_class;
    logic        mem_dest;
    logic        rep;
    logic        opsize_ovr;
    logic        addrsize_ovr;
    logic        far_xfer;
    logic        halt;
    logic        push_like;
    logic        soft_int;
    logic [7:0]  int_vec;
  } instr_t;

  typedef struct packed {
    logic        valid;
    mem_kind_t   kind;
    logic        numeric;
    logic [15:0] seg;
    logic [31:0] ea;
    logic [2:0]  size;
  } mem_ref_t;
endpackage

// ### lock_form_check.sv
`timescale 1ns/1ns
module lock_form_check (
  input  rmx_pkg::lock_class_t lock_class,
  input  wire logic            mem_dest,
  input  wire logic            rep,
  output logic                 lock_ok
);
  // No privilege input: lock legality is purely a form check
  always_comb begin
    lock_ok = (lock_class != rmx_pkg::LK_NONE) && mem_dest && !rep;
  end
endmodule

// ### real_addr_gen.sv
`timescale 1ns/1ns
module real_addr_gen (
  input  wire logic [15:0] seg,
  input  wire logic [31:0] ea,
  input  wire logic [2:0]  size,
  output logic      [20:0] phys,
  output logic             overrun
);
  logic [32:0] last_byte;

  always_comb begin
    phys = {1'b0, seg, 4'h0} + {5'h00, ea[15:0]};
    last_byte = {1'b0, ea} + {30'h0000_0000, size} - 33'h0_0000_0001;
    // Size zero counts as one byte
    overrun = (ea > rmx_pkg::SEG_LAST_OFS)
           || ((size != 3'h0) && (last_byte > {1'b0, rmx_pkg::SEG_LAST_OFS}));
  end
endmodule

// ### real_mode_exception_check.sv
`timescale 1ns/1ns
module real_mode_exception_check (
  input  wire logic             sys_clk,
  input  wire logic             rst,
  input  wire logic [1:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [31:0]      reg_rdata,
  input  rmx_pkg::instr_t       instr,
  input  rmx_pkg::mem_ref_t     mem,
  input  wire logic [15:0]      stack_pointer,
  input  wire logic             int_enable_flag,
  input  wire logic             nmi,
  input  wire logic             maskable_interrupt_request,
  input  wire logic             protect_enable,
  input  wire logic             fpu_err_report,
  input  wire logic [31:0]      fpu_err_ip,
  input  wire logic [31:0]      fpu_err_dp,
  input  wire logic             fpu_err_clear,
  input  wire logic [31:0]      instr_ip,
  output logic                  exc_valid,
  output logic      [7:0]       exc_vector,
  output logic                  exc_ret_next,
  output logic                  exc_pointer_ip,
  output logic                  shutdown_cycle,
  output logic                  halted,
  output logic                  in_shutdown,
  output logic                  wake,
  output logic                  real_mode,
  output logic                  op32,
  output logic                  addr32,
  output logic      [20:0]      phys_addr,
  output logic      [31:2]      addr_pins,
  output logic                  vector_area,
  output logic      [31:0]      fpu_ip,
  output logic      [31:0]      fpu_dp
);
  logic [2:0]  control_register_zero_q;
  logic [15:0] idt_limit_q;
  logic [31:0] rdata_q;
  logic        real_q;
  logic        cs_high_q;
  logic        pend_q;
  logic [31:0] ip_q;
  logic [31:0] dp_q;
  rmx_pkg::run_state_t state_q;
  rmx_pkg::run_state_t state_d;
  logic        exc_q;
  logic [7:0]  vec_q;
  logic        ret_next_q;
  logic        ptr_ip_q;
  logic        shut_cyc_q;
  logic        wake_q;
  logic        op32_q;
  logic        addr32_q;
  logic [20:0] phys_q;
  logic [31:2] pins_q;
  logic        vec_area_q;
  logic        lock_ok;
  logic [20:0] phys;
  logic        overrun;
  logic        raise;
  logic [7:0]  vec;
  logic        ret_next;
  logic        shut_req;
  logic        emulate_fpu_bit;
  logic        task_switched_bit;
  logic        nmi_ok;
  logic        far_taken;
  logic        halted_q;
  logic        in_shut_q;

  function automatic logic entry_beyond(input logic [7:0] v, input logic [15:0] lim);
    // Four-byte entries: last byte of entry v is 4v+3
    entry_beyond = {6'h00, v, 2'b11} > lim;
  endfunction

  assign emulate_fpu_bit = control_register_zero_q[rmx_pkg::CTRL_EM_BIT];
  assign task_switched_bit = control_register_zero_q[rmx_pkg::CTRL_TS_BIT];
  assign nmi_ok = (idt_limit_q >= rmx_pkg::NMI_LIMIT_MIN)
               && (stack_pointer > rmx_pkg::NMI_SP_MIN);
  assign far_taken = instr.valid && instr.far_xfer && state_q == rmx_pkg::ST_RUN;

  lock_form_check u_lock (
    .lock_class (instr.lock_class),
    .mem_dest   (instr.mem_dest),
    .rep        (instr.rep),
    .lock_ok    (lock_ok)
  );

  real_addr_gen u_addr (
    .seg     (mem.seg),
    .ea      (mem.ea),
    .size    (mem.size),
    .phys    (phys),
    .overrun (overrun)
  );

  // Register port
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      control_register_zero_q <= rmx_pkg::CTRL_RESET;
      idt_limit_q <= rmx_pkg::IDT_LIMIT_RESET;
    end else if (reg_wr) begin
      if (reg_addr == rmx_pkg::OFS_CTRL)
        control_register_zero_q <= reg_wdata[2:0];
      if (reg_addr == rmx_pkg::OFS_IDT_LIMIT)
        idt_limit_q <= reg_wdata[15:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        rmx_pkg::OFS_CTRL:      rdata_q <= {29'h0000_0000, control_register_zero_q};
        rmx_pkg::OFS_IDT_LIMIT: rdata_q <= {16'h0000, idt_limit_q};
        rmx_pkg::OFS_STATUS:    rdata_q <= {27'h000_0000, cs_high_q, pend_q,
                                            state_q == rmx_pkg::ST_SHUT,
                                            state_q == rmx_pkg::ST_HALT, real_q};
        default:                rdata_q <= 32'h0000_0000;
      endcase
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  // Mode and reset-vector window
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      real_q <= 1'b1;
    end else if (protect_enable) begin
      real_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cs_high_q <= 1'b1;
    end else if (far_taken) begin
      cs_high_q <= 1'b0;
    end
  end

  // FPU error record; a new error wins over a clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pend_q <= 1'b0;
      ip_q <= 32'h0000_0000;
      dp_q <= 32'h0000_0000;
    end else if (fpu_err_report) begin
      pend_q <= 1'b1;
      ip_q <= fpu_err_ip;
      dp_q <= fpu_err_dp;
    end else if (fpu_err_clear) begin
      pend_q <= 1'b0;
    end
  end

  // Exception selection, fixed order of checks
  always_comb begin
    raise = 1'b0;
    vec = 8'h00;
    ret_next = 1'b0;
    shut_req = 1'b0;
    if (instr.valid && state_q == rmx_pkg::ST_RUN) begin
      if (instr.lock && !lock_ok) begin
        raise = 1'b1;
        vec = rmx_pkg::VEC_INVALID_OP;
      end else if (instr.wait_op && task_switched_bit) begin
        raise = 1'b1;
        vec = rmx_pkg::VEC_NO_DEVICE;
      end else if (instr.fpu && (emulate_fpu_bit || task_switched_bit)) begin
        raise = 1'b1;
        vec = rmx_pkg::VEC_NO_DEVICE;
      end else if ((instr.fpu || instr.wait_op) && !instr.nowait && pend_q) begin
        raise = 1'b1;
        vec = rmx_pkg::VEC_FPU_ERR;
      end else if (real_q && mem.valid && overrun) begin
        if (mem.kind == rmx_pkg::MK_STACK) begin
          // Odd pointer wrap cannot be restarted
          if (instr.push_like && stack_pointer[0])
            shut_req = 1'b1;
          else begin
            raise = 1'b1;
            vec = rmx_pkg::VEC_STACK;
          end
        end else begin
          raise = 1'b1;
          vec = rmx_pkg::VEC_GENERAL;
        end
      end else if (instr.soft_int) begin
        raise = 1'b1;
        vec = instr.int_vec;
        ret_next = 1'b1;
      end
      if (raise && real_q && entry_beyond(vec, idt_limit_q)) begin
        if (vec == rmx_pkg::VEC_DOUBLE || vec == rmx_pkg::VEC_GENERAL
            || entry_beyond(rmx_pkg::VEC_DOUBLE, idt_limit_q)) begin
          raise = 1'b0;
          shut_req = 1'b1;
        end else begin
          vec = rmx_pkg::VEC_DOUBLE;
          ret_next = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      exc_q <= 1'b0;
      vec_q <= 8'h00;
      ret_next_q <= 1'b0;
      ptr_ip_q <= 1'b0;
    end else begin
      exc_q <= raise;
      vec_q <= vec;
      ret_next_q <= ret_next;
      ptr_ip_q <= raise && (vec == rmx_pkg::VEC_FPU_ERR);
    end
  end

  // Halt and shutdown
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      rmx_pkg::ST_RUN: begin
        if (shut_req)
          state_d = rmx_pkg::ST_SHUT;
        else if (instr.valid && instr.halt && !raise)
          state_d = rmx_pkg::ST_HALT;
      end
      rmx_pkg::ST_HALT: begin
        if (nmi || (maskable_interrupt_request && int_enable_flag))
          state_d = rmx_pkg::ST_RUN;
      end
      rmx_pkg::ST_SHUT: begin
        if (nmi && nmi_ok)
          state_d = rmx_pkg::ST_RUN;
      end
      default: state_d = rmx_pkg::ST_RUN;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= rmx_pkg::ST_RUN;
      halted_q <= 1'b0;
      in_shut_q <= 1'b0;
      wake_q <= 1'b0;
      shut_cyc_q <= 1'b0;
    end else begin
      state_q <= state_d;
      halted_q <= (state_d == rmx_pkg::ST_HALT);
      in_shut_q <= (state_d == rmx_pkg::ST_SHUT);
      wake_q <= (state_q != rmx_pkg::ST_RUN) && (state_d == rmx_pkg::ST_RUN);
      // Entry, or a refused NMI, each issue one shutdown cycle
      shut_cyc_q <= (state_q == rmx_pkg::ST_RUN && shut_req)
                 || (state_q == rmx_pkg::ST_SHUT && nmi && !nmi_ok);
    end
  end

  // Sizes and address pins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op32_q <= 1'b0;
      addr32_q <= 1'b0;
      phys_q <= 21'h00_0000;
      pins_q <= 30'h0000_0000;
      vec_area_q <= 1'b0;
    end else begin
      if (instr.valid) begin
        op32_q <= instr.opsize_ovr;
        addr32_q <= instr.addrsize_ovr;
      end
      if (mem.valid) begin
        phys_q <= phys;
        vec_area_q <= real_q && (phys <= rmx_pkg::VECTOR_AREA_END);
        if (cs_high_q && !far_taken && mem.kind == rmx_pkg::MK_CODE)
          pins_q <= 30'h3fff_ffff;
        else if (real_q)
          pins_q <= {12'h000, phys[19:2]};
        else
          pins_q <= mem.ea[31:2];
      end else if (far_taken && real_q) begin
        // Closing the window must not leave stale high lines above A19
        pins_q <= {12'h000, pins_q[19:2]};
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign exc_valid = exc_q;
  assign exc_vector = vec_q;
  assign exc_ret_next = ret_next_q;
  assign exc_pointer_ip = ptr_ip_q;
  assign shutdown_cycle = shut_cyc_q;
  assign halted = halted_q;
  assign in_shutdown = in_shut_q;
  assign wake = wake_q;
  assign real_mode = real_q;
  assign op32 = op32_q;
  assign addr32 = addr32_q;
  assign phys_addr = phys_q;
  assign addr_pins = pins_q;
  assign vector_area = vec_area_q;
  assign fpu_ip = ip_q;
  assign fpu_dp = dp_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_em_raises_seven: assert property (
    instr.valid && instr.fpu && emulate_fpu_bit && state_q == rmx_pkg::ST_RUN
    && !(instr.lock && !lock_ok) && idt_limit_q >= 16'h001f
    |=> exc_valid && exc_vector == 8'h07)
    else $error("fpu with emulate bit did not raise 7");
  a_wait_ts_seven: assert property (
    instr.valid && instr.wait_op && task_switched_bit && state_q == rmx_pkg::ST_RUN
    && !instr.lock && idt_limit_q >= 16'h001f |=> exc_valid && exc_vector == 8'h07)
    else $error("wait with task switched did not raise 7");
  a_nowait_no_sixteen: assert property (
    instr.valid && instr.nowait |=> !(exc_valid && exc_vector == 8'h10))
    else $error("no-wait form raised 16");
  a_error_ptrs_hold: assert property (
    !fpu_err_report |=> $stable(fpu_ip) && $stable(fpu_dp))
    else $error("fpu pointers moved without an error");
  a_bad_lock_six: assert property (
    instr.valid && instr.lock && instr.rep && state_q == rmx_pkg::ST_RUN
    |=> exc_valid && (exc_vector == 8'h06 || exc_vector == 8'h08))
    else $error("locked repeat string not refused");
  a_pins_one_meg: assert property (
    real_mode && !cs_high_q |-> addr_pins[31:20] == 12'h000)
    else $error("real mode drove address above A19");
  a_no_prot_vectors: assert property (
    exc_valid && real_mode |-> !(exc_vector inside {8'h0a, 8'h0b, 8'h0e, 8'h11}))
    else $error("protected-only vector in real mode");
  a_stack_overrun: assert property (
    instr.valid && real_mode && mem.valid && mem.kind == rmx_pkg::MK_STACK
    && mem.ea == 32'h0001_0000 && !instr.lock && !instr.fpu && !instr.wait_op
    && state_q == rmx_pkg::ST_RUN && idt_limit_q == 16'h03ff
    && !(instr.push_like && stack_pointer[0])
    |=> exc_valid && exc_vector == 8'h0c && !exc_ret_next)
    else $error("stack overrun did not raise 12");
  a_halt_holds: assert property (
    halted && !nmi && !maskable_interrupt_request |=> halted)
    else $error("halt left without a wake source");
  a_shut_nmi_gate: assert property (
    in_shutdown && nmi && idt_limit_q < 16'h0017 |=> in_shutdown ##0 shutdown_cycle)
    else $error("nmi left shutdown with small table");

  c_halt_wake: cover property (halted ##1 wake);
  c_fpu_err_raise: cover property (exc_valid && exc_vector == 8'h10);
  c_shutdown_exit: cover property (in_shutdown ##1 !in_shutdown);
endmodule

// ### real_mode_exception_check_tb.sv
`timescale 1ns/1ns
module real_mode_exception_check_tb;
  logic                sys_clk = 1'b0;
  logic                rst = 1'b1;
  logic [1:0]          reg_addr = 2'h0;
  logic [31:0]         reg_wdata = 32'h0000_0000;
  logic                reg_wr = 1'b0;
  logic                reg_rd = 1'b0;
  logic [31:0]         reg_rdata;
  rmx_pkg::instr_t     instr = '0;
  rmx_pkg::mem_ref_t   mem = '0;
  logic [15:0]         stack_pointer = 16'h0100;
  logic                int_enable_flag = 1'b0;
  logic                nmi = 1'b0;
  logic                maskable_interrupt_request = 1'b0;
  logic                protect_enable = 1'b0;
  logic                fpu_err_report = 1'b0;
  logic [31:0]         fpu_err_ip = 32'h0000_0000;
  logic [31:0]         fpu_err_dp = 32'h0000_0000;
  logic                fpu_err_clear = 1'b0;
  logic                exc_valid, exc_ret_next, exc_pointer_ip, shutdown_cycle;
  logic                halted, in_shutdown, wake, real_mode, op32, addr32, vector_area;
  logic [7:0]          exc_vector;
  logic [20:0]         phys_addr;
  logic [31:2]         addr_pins;
  logic [31:0]         fpu_ip, fpu_dp;
  int                  miscompares = 0;
  int                  n_checks = 0;

  real_mode_exception_check dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .instr(instr), .mem(mem), .stack_pointer(stack_pointer),
    .int_enable_flag(int_enable_flag), .nmi(nmi),
    .maskable_interrupt_request(maskable_interrupt_request),
    .protect_enable(protect_enable), .fpu_err_report(fpu_err_report),
    .fpu_err_ip(fpu_err_ip), .fpu_err_dp(fpu_err_dp), .fpu_err_clear(fpu_err_clear),
    .instr_ip(32'h0000_0000), .exc_valid(exc_valid), .exc_vector(exc_vector),
    .exc_ret_next(exc_ret_next), .exc_pointer_ip(exc_pointer_ip),
    .shutdown_cycle(shutdown_cycle), .halted(halted), .in_shutdown(in_shutdown),
    .wake(wake), .real_mode(real_mode), .op32(op32), .addr32(addr32),
    .phys_addr(phys_addr), .addr_pins(addr_pins), .vector_area(vector_area),
    .fpu_ip(fpu_ip), .fpu_dp(fpu_dp));

  always #5 sys_clk = ~sys_clk;

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic rmx_pkg::instr_t ins();
    ins = '0;
    ins.valid = 1'b1;
  endfunction

  function automatic rmx_pkg::mem_ref_t mr(input rmx_pkg::mem_kind_t k,
                                           input logic [15:0] s, input logic [31:0] e,
                                           input logic [2:0] z);
    mr = '0;
    mr.valid = 1'b1;
    mr.kind = k;
    mr.seg = s;
    mr.ea = e;
    mr.size = z;
  endfunction

  // Outputs of the taken edge are sampled 1 ns after it
  task automatic send(input rmx_pkg::instr_t i, input rmx_pkg::mem_ref_t m);
    @(posedge sys_clk);
    instr <= i;
    mem <= m;
    @(posedge sys_clk);
    instr <= '0;
    mem <= '0;
    #1;
    if (exc_valid === 1'b1) begin
      check(32'(exc_vector inside {8'h0a, 8'h0b, 8'h0e, 8'h11}), 32'h0);
    end
  endtask

  task automatic exc(input logic v, input logic [7:0] vec, input logic nxt);
    check(32'(exc_valid), 32'(v));
    if (v) begin
      check(32'({exc_vector, exc_ret_next}), 32'({vec, nxt}));
    end
  endtask

  task automatic wr(input logic [1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask

  // Selector: 0 error report, 1 error clear, 2 nmi, 3 protect enable
  task automatic pulse(input int k);
    @(posedge sys_clk);
    {protect_enable, nmi, fpu_err_clear, fpu_err_report} <= 4'(1 << k);
    @(posedge sys_clk);
    {protect_enable, nmi, fpu_err_clear, fpu_err_report} <= 4'h0;
    #1;
  endtask

  task automatic do_reset();
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    check(32'({real_mode, halted, in_shutdown}), 32'h4);
  endtask

  task automatic t_regs_addr();
    rd(2'h2, 32'h0000_0011);
    rd(2'h1, 32'h0000_03ff);
    rd(2'h3, 32'h0000_0000);
    wr(2'h2, 32'h0000_0000);
    rd(2'h2, 32'h0000_0011);
    send(ins(), mr(rmx_pkg::MK_CODE, 16'h1234, 32'h0000_0010, 3'h0));
    check(32'(addr_pins), 32'h3fff_ffff);
    check(32'(phys_addr), 32'h0001_2350);
    begin
      rmx_pkg::instr_t f;
      f = ins();
      f.far_xfer = 1'b1;
      send(f, '0);
    end
    send(ins(), mr(rmx_pkg::MK_CODE, 16'h1234, 32'h0000_0010, 3'h0));
    check(32'(addr_pins), 32'h0000_48d4);
    send(ins(), mr(rmx_pkg::MK_DATA, 16'hffff, 32'h0000_ffff, 3'h0));
    check(32'(phys_addr), 32'h0010_ffef);
    send(ins(), mr(rmx_pkg::MK_DATA, 16'h0000, 32'h0000_03fc, 3'h3));
    check(32'(vector_area), 32'h1);
    send(ins(), mr(rmx_pkg::MK_DATA, 16'h0000, 32'h0000_0400, 3'h0));
    check(32'(vector_area), 32'h0);
  endtask

  task automatic t_overrun();
    send(ins(), mr(rmx_pkg::MK_DATA, 16'h2000, 32'h0000_fffe, 3'h2));
    exc(1'b0, 8'h00, 1'b0);
    send(ins(), mr(rmx_pkg::MK_DATA, 16'h2000, 32'h0000_ffff, 3'h2));
    exc(1'b1, rmx_pkg::VEC_GENERAL, 1'b0);
    send(ins(), mr(rmx_pkg::MK_CODE, 16'h2000, 32'h0001_0000, 3'h0));
    exc(1'b1, rmx_pkg::VEC_GENERAL, 1'b0);
    send(ins(), mr(rmx_pkg::MK_STACK, 16'h2000, 32'h0000_fffe, 3'h3));
    exc(1'b1, rmx_pkg::VEC_STACK, 1'b0);
    send(ins(), mr(rmx_pkg::MK_STACK, 16'h2000, 32'h0001_0000, 3'h0));
    exc(1'b1, rmx_pkg::VEC_STACK, 1'b0);
  endtask

  task automatic t_fpu();
    rmx_pkg::instr_t f, w;
    rmx_pkg::mem_ref_t m;
    f = ins();
    f.fpu = 1'b1;
    w = ins();
    w.wait_op = 1'b1;
    m = mr(rmx_pkg::MK_DATA, 16'h3000, 32'h0000_fffc, 3'h7);
    m.numeric = 1'b1;
    wr(2'h0, 32'h0000_0001);
    rd(2'h0, 32'h0000_0001);
    send(f, '0);
    exc(1'b1, rmx_pkg::VEC_NO_DEVICE, 1'b0);
    send(w, '0);
    exc(1'b0, 8'h00, 1'b0);
    wr(2'h0, 32'h0000_0002);
    send(w, '0);
    exc(1'b1, rmx_pkg::VEC_NO_DEVICE, 1'b0);
    send(f, '0);
    exc(1'b1, rmx_pkg::VEC_NO_DEVICE, 1'b0);
    wr(2'h0, 32'h0000_0000);
    send(f, m);
    exc(1'b1, rmx_pkg::VEC_GENERAL, 1'b0);
    check(fpu_ip, 32'h0000_0000);
    @(posedge sys_clk);
    fpu_err_ip <= 32'h0000_1234;
    fpu_err_dp <= 32'h0000_5678;
    pulse(0);
    check(fpu_ip, 32'h0000_1234);
    check(fpu_dp, 32'h0000_5678);
    f.nowait = 1'b1;
    send(f, '0);
    exc(1'b0, 8'h00, 1'b0);
    send(w, '0);
    exc(1'b1, rmx_pkg::VEC_FPU_ERR, 1'b0);
    check(32'(exc_pointer_ip), 32'h1);
    pulse(1);
    f.nowait = 1'b0;
    send(f, '0);
    exc(1'b0, 8'h00, 1'b0);
  endtask

  task automatic t_lock();
    rmx_pkg::instr_t l;
    l = ins();
    l.lock = 1'b1;
    for (int c = 0; c < 6; c++) begin
      l.lock_class = rmx_pkg::lock_class_t'(c);
      l.mem_dest = 1'b1;
      l.rep = 1'b0;
      send(l, '0);
      exc(c == 0, rmx_pkg::VEC_INVALID_OP, 1'b0);
      l.rep = 1'b1;
      send(l, '0);
      exc(1'b1, rmx_pkg::VEC_INVALID_OP, 1'b0);
      l.rep = 1'b0;
      l.mem_dest = 1'b0;
      send(l, '0);
      exc(1'b1, rmx_pkg::VEC_INVALID_OP, 1'b0);
    end
  endtask

  task automatic t_int_shutdown();
    rmx_pkg::instr_t s;
    s = ins();
    s.soft_int = 1'b1;
    s.int_vec = 8'h21;
    send(s, '0);
    exc(1'b1, 8'h21, 1'b1);
    wr(2'h1, 32'h0000_0027);
    s.int_vec = 8'h20;
    send(s, '0);
    exc(1'b1, rmx_pkg::VEC_DOUBLE, 1'b0);
    s.int_vec = 8'h0d;
    send(s, '0);
    check(32'(in_shutdown), 32'h1);
    send(ins(), mr(rmx_pkg::MK_DATA, 16'h0, 32'h0001_0000, 3'h0));
    exc(1'b0, 8'h00, 1'b0);
    wr(2'h1, 32'h0000_000f);
    stack_pointer <= 16'h0010;
    pulse(2);
    check(32'({shutdown_cycle, wake, in_shutdown}), 32'h5);
    wr(2'h1, 32'h0000_0017);
    stack_pointer <= 16'h0005;
    pulse(2);
    check(32'({shutdown_cycle, wake, in_shutdown}), 32'h5);
    stack_pointer <= 16'h0006;
    pulse(2);
    check(32'({wake, in_shutdown}), 32'h2);
    s = ins();
    s.push_like = 1'b1;
    stack_pointer <= 16'h0001;
    send(s, mr(rmx_pkg::MK_STACK, 16'h0, 32'h0000_ffff, 3'h2));
    check(32'(in_shutdown), 32'h1);
    stack_pointer <= 16'h0100;
    do_reset();
  endtask

  task automatic t_halt_mode();
    rmx_pkg::instr_t h;
    h = ins();
    h.halt = 1'b1;
    send(h, '0);
    check(32'(halted), 32'h1);
    maskable_interrupt_request <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    check(32'({halted, wake}), 32'h2);
    int_enable_flag <= 1'b1;
    @(posedge sys_clk);
    #1;
    check(32'({halted, wake}), 32'h1);
    maskable_interrupt_request <= 1'b0;
    send(h, '0);
    pulse(2);
    check(32'({halted, wake}), 32'h1);
    h = ins();
    h.opsize_ovr = 1'b1;
    send(h, '0);
    check(32'({op32, addr32}), 32'h2);
    send(ins(), '0);
    check(32'({op32, addr32}), 32'h0);
    h.opsize_ovr = 1'b0;
    h.addrsize_ovr = 1'b1;
    send(h, '0);
    check(32'({op32, addr32}), 32'h1);
    pulse(3);
    @(posedge sys_clk);
    #1;
    check(32'(real_mode), 32'h0);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    check(32'({real_mode, op32, exc_valid}), 32'h4);
    t_regs_addr();
    t_overrun();
    t_fpu();
    t_lock();
    t_int_shutdown();
    t_halt_mode();
    give_verdict();
  end
endmodule
